// ### hw/ashp_pkg.sv
package ashp_pkg;
   // ----------------------------------------------------------------
   // Link and control byte layout
   // ----------------------------------------------------------------
   localparam int ASHP_RES_W = 16;
   localparam int ASHP_CB_W = 8;
   localparam int ASHP_CB_START = 7;
   localparam int ASHP_CB_BIP = 6;
   localparam int ASHP_CB_INT = 5;
   localparam int ASHP_CB_LONG = 4;
   localparam int ASHP_CB_CAL = 3;
   localparam logic [15:0] ASHP_BIP_FLIP = 16'h8000;
   localparam logic [5:0] ASHP_SHORT_ACQ = 6'h08;
   localparam logic [5:0] ASHP_LONG_ACQ = 6'h10;
   localparam logic [5:0] ASHP_RES_LAST = 6'h0f;
   localparam logic [2:0] ASHP_CTRL_LAST = 3'h7;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int ASHP_CLK_MHZ = 250;
   localparam int ASHP_INT_CONV_NS = 256;
   localparam int ASHP_INT_CONV_CYC = ASHP_INT_CONV_NS * ASHP_CLK_MHZ / 1000;
   localparam int ASHP_SCLK_HALF = 8;

   // ----------------------------------------------------------------
   // Host register map
   // ----------------------------------------------------------------
   localparam logic [7:0] ASHP_OFF_CTRL = 8'h00;
   localparam logic [7:0] ASHP_OFF_STAT = 8'h04;
   localparam logic [7:0] ASHP_OFF_RX = 8'h08;
   localparam logic [7:0] ASHP_OFF_IRQ = 8'h0c;
   localparam logic [7:0] ASHP_OFF_MASK = 8'h10;
   localparam logic [7:0] ASHP_OFF_PIN = 8'h14;
   localparam int ASHP_LEN_LSB = 8;
   localparam int ASHP_LEN_W = 6;
   localparam int ASHP_IRQ_DONE = 0;
   localparam int ASHP_IRQ_STRB = 1;
   localparam int ASHP_PIN_PD = 0;
   localparam int ASHP_PIN_RST = 1;
   localparam logic [1:0] ASHP_PIN_RST_VAL = 2'h3;

   typedef enum logic [4:0] {
      ASHP_HUNT  = 5'h01,
      ASHP_CTRL  = 5'h02,
      ASHP_EACQ  = 5'h04,
      ASHP_ECONV = 5'h08,
      ASHP_ICONV = 5'h10
   } ashp_state_t;
endpackage

// ### hw/ashp_if.sv
`timescale 1ns/1ps
interface ashp_if;
   logic cs_n;
   logic sclk;
   logic din;
   logic dout;
   logic dout_oe;
   logic strobe;
   logic strobe_oe;
   logic power_down_n;
   logic rst_n;
   logic user_out_zero;
   logic user_out_one;
   logic user_out_two;
   wire dout_w;
   wire strobe_w;

   // Released lines show the inverse of the last driven value
   assign dout_w = dout_oe ? dout : !dout;
   assign strobe_w = strobe_oe ? strobe : !strobe;

   modport dev (
      input cs_n, sclk, din, power_down_n, rst_n,
      output dout, dout_oe, strobe, strobe_oe, user_out_zero, user_out_one, user_out_two
   );
   modport host (
      output cs_n, sclk, din, power_down_n, rst_n,
      input dout_w, strobe_w, user_out_zero, user_out_one, user_out_two
   );
endinterface

// ### hw/ashp_sync.sv
`timescale 1ns/1ps
module ashp_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,           // Sampling clock
   input wire logic rst_n,         // Async reset, active low
   input wire logic [W-1:0] d,     // Asynchronous inputs
   output logic [W-1:0] q          // Synchronised outputs
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// ### hw/ashp_device.sv
`timescale 1ns/1ps
// Behaviour
// R01: Power-down input low holds device in shutdown
// R02: Internal mode: strobe low during conversion
// R03: External mode: strobe high one period before MSB
// R04: External mode: strobe released while select high
// R05: Result shifted out MSB first
// R06: Unipolar straight binary, bipolar two's complement
// R07: Output updated on falling serial clock
// R08: Hard reset restores all power-on defaults
// R09: Control bits latched on rising serial clock
// R10: External mode: serial clock paces conversion
// R11: Select high makes device ignore traffic
// R12: Serial output released while select high
// R13: First one after select/completion starts byte
// R14: User outputs follow bits 0-2, cleared on reset
// R15: Short acquisition: strobe after seventh fall
// R16: New start bit aborts current conversion
// R17: Reset asynchronous, release synchronous, no partial byte
module ashp_device import ashp_pkg::*; #(
   parameter int CONV_CYC = ASHP_INT_CONV_CYC
) (
   input wire logic pclk,                  // System clock
   input wire logic presetn,               // Async reset, active low
   ashp_if.dev link,                       // Serial link pins
   input wire logic [15:0] analog_code,    // Digitised input, offset binary
   output logic shutdown,                  // Device in shutdown
   output logic busy                       // Acquisition or conversion running
);
   // ----------------------------------------------------------------
   // Result coding
   // ----------------------------------------------------------------
   function automatic logic [15:0] code_of(input logic bip, input logic [15:0] raw);
      // R06: range coding
      code_of = bip ? (raw ^ ASHP_BIP_FLIP) : raw;
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers and edges
   // ----------------------------------------------------------------
   logic sclk_s;
   logic cs_n_s;
   logic din_s;
   logic pd_n_s;
   logic rst_n_s;
   logic sclk_d_q;
   logic cs_n_d_q;

   ashp_sync #(.W(5), .RST_VAL(5'h0b)) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d({link.sclk, link.cs_n, link.din, link.power_down_n, link.rst_n}),
      .q({sclk_s, cs_n_s, din_s, pd_n_s, rst_n_s})
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_d_q <= 1'b0;
         cs_n_d_q <= 1'b1;
      end else begin
         sclk_d_q <= sclk_s;
         cs_n_d_q <= cs_n_s;
      end
   end

   // R11: edges count only while selected and powered
   wire active = !cs_n_s && pd_n_s;
   wire rise = active && sclk_s && !sclk_d_q;
   wire fall = active && !sclk_s && sclk_d_q;
   wire cs_fall = !cs_n_s && cs_n_d_q;

   // ----------------------------------------------------------------
   // Sequencer state
   // ----------------------------------------------------------------
   ashp_state_t state_q;
   logic [7:0] ctl_q;
   logic [2:0] idx_q;
   logic [5:0] fcnt_q;
   logic [15:0] res_q;
   logic [2:0] pout_q;
   logic ext_q;
   logic bip_q;
   logic armed_q;
   logic dout_q;
   logic strobe_q;
   logic [$clog2(CONV_CYC+1)-1:0] conv_q;

   wire hunting = (state_q == ASHP_HUNT);
   // R13: start bit is first one while hunting or after reselect
   wire start_seen = rise && din_s && (hunting || armed_q);
   // R09: control bit latched on rising edge
   wire ctl_bit = rise && (state_q == ASHP_CTRL);
   wire ctl_done = ctl_bit && (idx_q == ASHP_CTRL_LAST);
   wire mode_bit = ctl_bit && ((3'h7 - idx_q) == ASHP_CB_INT[2:0]);
   wire [7:0] byte_full = ctl_q | ({7'h00, din_s} << (3'h7 - idx_q));
   wire ctl_ext = !ctl_q[ASHP_CB_INT];
   wire ctl_cal = ctl_q[ASHP_CB_CAL];
   wire [5:0] acq_len = ctl_q[ASHP_CB_LONG] ? ASHP_LONG_ACQ : ASHP_SHORT_ACQ;
   wire [5:0] fcnt_n = fcnt_q + 6'h01;
   wire ext_seq = (state_q == ASHP_CTRL) || (state_q == ASHP_EACQ) || (state_q == ASHP_ECONV);
   // R15: strobe rises on the fall before the MSB fall
   wire strb_set = fall && ext_seq && ctl_ext && !ctl_cal && (fcnt_n == acq_len - 6'h01);
   wire msb_fall = fall && (state_q == ASHP_EACQ) && (fcnt_n == acq_len);
   wire last_fall = fall && (state_q == ASHP_ECONV) && (fcnt_n == acq_len + ASHP_RES_LAST);
   wire int_done = (state_q == ASHP_ICONV) && (conv_q == CONV_CYC[$bits(conv_q)-1:0] - 1'b1);
   wire [15:0] code_now = code_of(bip_q, analog_code);

   // ----------------------------------------------------------------
   // Control path
   // ----------------------------------------------------------------
   // R08: hard reset pin or presetn returns defaults; R17
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ASHP_HUNT;
         ctl_q <= 8'h00;
         idx_q <= 3'h0;
         fcnt_q <= 6'h00;
         pout_q <= 3'h0;
         ext_q <= 1'b0;
         bip_q <= 1'b0;
         armed_q <= 1'b0;
         conv_q <= '0;
      end else if (!rst_n_s) begin
         // R17: partial byte discarded on hard reset
         state_q <= ASHP_HUNT;
         ctl_q <= 8'h00;
         idx_q <= 3'h0;
         fcnt_q <= 6'h00;
         // R14: user outputs cleared by hard reset
         pout_q <= 3'h0;
         ext_q <= 1'b0;
         bip_q <= 1'b0;
         armed_q <= 1'b0;
         conv_q <= '0;
      end else if (!pd_n_s) begin
         // R01: shutdown stops sequencing, user outputs kept
         state_q <= ASHP_HUNT;
         armed_q <= 1'b0;
      end else if (start_seen) begin
         // R16: fresh byte abandons any running conversion
         state_q <= ASHP_CTRL;
         ctl_q <= 8'h80;
         idx_q <= 3'h1;
         fcnt_q <= 6'h00;
         armed_q <= 1'b0;
      end else begin
         if (cs_fall && !hunting) begin
            armed_q <= 1'b1;
         end
         if (fall && ext_seq) begin
            fcnt_q <= fcnt_n;
         end
         if (ctl_bit) begin
            ctl_q <= byte_full;
            idx_q <= idx_q + 3'h1;
         end
         if (ctl_done) begin
            // R14: user outputs follow control bits 0-2
            pout_q <= byte_full[2:0];
            ext_q <= !byte_full[ASHP_CB_INT];
            bip_q <= byte_full[ASHP_CB_BIP];
            conv_q <= '0;
            state_q <= byte_full[ASHP_CB_INT] ? ASHP_ICONV : ASHP_EACQ;
         end
         // R10: external conversion paced by serial clock falls
         if (msb_fall) begin
            state_q <= ASHP_ECONV;
         end
         if (last_fall) begin
            state_q <= ASHP_HUNT;
         end
         if (state_q == ASHP_ICONV) begin
            conv_q <= conv_q + 1'b1;
         end
         if (int_done) begin
            state_q <= ASHP_HUNT;
         end
      end
   end

   // ----------------------------------------------------------------
   // Data and strobe path
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res_q <= 16'h0000;
         dout_q <= 1'b0;
         strobe_q <= 1'b1;
      end else if (!rst_n_s) begin
         res_q <= 16'h0000;
         dout_q <= 1'b0;
         strobe_q <= 1'b1;
      end else if (!pd_n_s || start_seen) begin
         strobe_q <= !ext_q;
      end else if (mode_bit) begin
         // Idle level follows the clock mode being loaded
         strobe_q <= din_s;
      end else if (ctl_done && byte_full[ASHP_CB_INT]) begin
         // R02: internal conversion pulls strobe low
         strobe_q <= 1'b0;
      end else if (int_done) begin
         // R02: strobe high again once finished
         strobe_q <= 1'b1;
         if (!ctl_cal) begin
            dout_q <= code_now[15];
            res_q <= {code_now[14:0], 1'b0};
         end
      end else if (strb_set) begin
         // R03: one serial period ahead of MSB decision
         strobe_q <= 1'b1;
      end else if (msb_fall) begin
         strobe_q <= 1'b0;
         if (!ctl_cal) begin
            // R05: MSB first; R07: on the falling edge
            dout_q <= code_now[15];
            res_q <= {code_now[14:0], 1'b0};
         end
      end else if (fall) begin
         // R07: next bit on each falling edge
         dout_q <= res_q[15];
         res_q <= {res_q[14:0], 1'b0};
      end
   end

   // ----------------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------------
   assign link.dout = dout_q;
   // R12: serial output released while deselected
   assign link.dout_oe = !cs_n_s;
   assign link.strobe = strobe_q;
   // R04: strobe released while deselected in external mode
   assign link.strobe_oe = ext_q ? !cs_n_s : 1'b1;
   assign link.user_out_zero = pout_q[0];
   assign link.user_out_one = pout_q[1];
   assign link.user_out_two = pout_q[2];
   assign shutdown = !pd_n_s;
   assign busy = !hunting;
endmodule

// ### hw/ashp_host.sv
`timescale 1ns/1ps
module ashp_host import ashp_pkg::*; #(
   parameter int SCLK_HALF = ASHP_SCLK_HALF
) (
   input wire logic pclk,             // System clock
   input wire logic presetn,          // Async reset, active low
   input wire logic psel,             // APB select
   input wire logic penable,          // APB enable
   input wire logic pwrite,           // APB write
   input wire logic [7:0] paddr,      // APB byte address
   input wire logic [31:0] pwdata,    // APB write data
   output logic [31:0] prdata,        // APB read data
   output logic pready,               // APB ready
   output logic pslverr,              // APB error on unmapped address
   output logic irq,                  // Interrupt, active high level
   ashp_if.host link                  // Serial link pins
);
   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   wire acc = psel && penable;
   wire wr = acc && pwrite;
   wire hit_ctrl = (paddr == ASHP_OFF_CTRL);
   wire hit_stat = (paddr == ASHP_OFF_STAT);
   wire hit_rx = (paddr == ASHP_OFF_RX);
   wire hit_irq = (paddr == ASHP_OFF_IRQ);
   wire hit_mask = (paddr == ASHP_OFF_MASK);
   wire hit_pin = (paddr == ASHP_OFF_PIN);
   wire mapped = hit_ctrl | hit_stat | hit_rx | hit_irq | hit_mask | hit_pin;

   logic busy_q;
   logic sclk_q;
   logic cs_n_q;
   logic din_q;
   logic [7:0] tx_q;
   logic [31:0] rx_q;
   logic [5:0] cnt_q;
   logic [5:0] len_q;
   logic [$clog2(SCLK_HALF)-1:0] div_q;
   logic [1:0] irq_q;
   logic [1:0] mask_q;
   logic [1:0] pin_q;
   logic dout_s;
   logic strobe_s;
   logic strobe_d_q;

   ashp_sync #(.W(2), .RST_VAL(2'h1)) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d({link.dout_w, link.strobe_w}),
      .q({dout_s, strobe_s})
   );

   // ----------------------------------------------------------------
   // Serial clock divider and shifter
   // ----------------------------------------------------------------
   wire tick = busy_q && (div_q == SCLK_HALF[$bits(div_q)-1:0] - 1'b1);
   wire start = wr && hit_ctrl && !busy_q;
   wire finish = tick && !sclk_q && (cnt_q == len_q);
   wire strb_rise = strobe_s && !strobe_d_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_q <= 1'b0;
         sclk_q <= 1'b0;
         cs_n_q <= 1'b1;
         din_q <= 1'b0;
         tx_q <= 8'h00;
         rx_q <= 32'h0;
         cnt_q <= 6'h00;
         len_q <= 6'h00;
         div_q <= '0;
      end else if (start) begin
         // R11: select low for the whole exchange
         busy_q <= 1'b1;
         cs_n_q <= 1'b0;
         din_q <= pwdata[7];
         tx_q <= {pwdata[6:0], 1'b0};
         len_q <= pwdata[ASHP_LEN_LSB +: ASHP_LEN_W];
         cnt_q <= 6'h00;
         rx_q <= 32'h0;
         div_q <= '0;
      end else if (busy_q) begin
         div_q <= tick ? '0 : div_q + 1'b1;
         if (finish) begin
            busy_q <= 1'b0;
            cs_n_q <= 1'b1;
            din_q <= 1'b0;
         end else if (tick && !sclk_q) begin
            // R07: sample half a period after the presenting fall
            sclk_q <= 1'b1;
            rx_q <= {rx_q[30:0], dout_s};
            cnt_q <= cnt_q + 6'h01;
         end else if (tick) begin
            // R09: data changes while clock low, stable at rise
            sclk_q <= 1'b0;
            din_q <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers and interrupt
   // ----------------------------------------------------------------
   wire [1:0] irq_set = {strb_rise, finish};
   wire [1:0] irq_clr = (wr && hit_irq) ? pwdata[1:0] : 2'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 2'h0;
         mask_q <= 2'h0;
         pin_q <= ASHP_PIN_RST_VAL;
         strobe_d_q <= 1'b1;
      end else begin
         strobe_d_q <= strobe_s;
         // Set wins over a same-cycle clear
         irq_q <= (irq_q & ~irq_clr) | irq_set;
         if (wr && hit_mask) begin
            mask_q <= pwdata[1:0];
         end
         if (wr && hit_pin) begin
            pin_q <= pwdata[1:0];
         end
      end
   end

   always_comb begin
      prdata = 32'h0;
      if (acc && !pwrite) begin
         if (hit_stat) prdata = {29'h0, !pin_q[ASHP_PIN_PD], strobe_s, busy_q};
         if (hit_rx) prdata = rx_q;
         if (hit_irq) prdata = {30'h0, irq_q};
         if (hit_mask) prdata = {30'h0, mask_q};
         if (hit_pin) prdata = {30'h0, pin_q};
         if (hit_ctrl) prdata = {18'h0, len_q, tx_q};
      end
   end

   assign pready = 1'b1;
   assign pslverr = acc && !mapped;
   assign irq = |(irq_q & mask_q);
   assign link.cs_n = cs_n_q;
   assign link.sclk = sclk_q;
   assign link.din = din_q;
   // R01: shutdown pin from register
   assign link.power_down_n = pin_q[ASHP_PIN_PD];
   // R08: hard reset pin from register
   assign link.rst_n = pin_q[ASHP_PIN_RST];
endmodule

// ### sim/ashp_properties.sv
`timescale 1ns/1ps
module ashp_properties (
   input wire logic pclk, // System clock
   input wire logic presetn, // Async reset, active low
   input wire logic cs_n, // Select, active low
   input wire logic sclk, // Serial clock
   input wire logic din, // Host serial data
   input wire logic dout, // Device serial data
   input wire logic dout_oe, // Device drives dout
   input wire logic strobe, // Conversion strobe
   input wire logic strobe_oe, // Device drives strobe
   input wire logic power_down_n, // Shutdown, active low
   input wire logic rst_n, // Hard reset, active low
   input wire logic user_out_zero, // User output 0
   input wire logic user_out_one, // User output 1
   input wire logic user_out_two // User output 2
);
   // ----------------------------------------------------------------
   // Link properties
   // ----------------------------------------------------------------
   default clocking ck @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_dout_off;
      cs_n [*4] |-> !dout_oe;
   endproperty
   a_dout_off: assert property (p_dout_off) else $error("dout driven while deselected");
   property p_dout_on;
      (!cs_n) [*4] |-> dout_oe;
   endproperty
   a_dout_on: assert property (p_dout_on) else $error("dout not driven while selected");
   property p_sclk_idle;
      cs_n |-> !sclk;
   endproperty
   a_sclk_idle: assert property (p_sclk_idle) else $error("sclk high while deselected");
   property p_din_low;
      $changed(din) |-> !sclk;
   endproperty
   a_din_low: assert property (p_din_low) else $error("din changed while sclk high");
   property p_sclk_half;
      $rose(sclk) |-> sclk [*8] ##1 !sclk;
   endproperty
   a_sclk_half: assert property (p_sclk_half) else $error("sclk high phase wrong");
   property p_dout_hold;
      sclk && $past(sclk, 4) && strobe && $past(strobe) && dout_oe && $past(dout_oe)
         |-> $stable(dout);
   endproperty
   a_dout_hold: assert property (p_dout_hold) else $error("dout moved while sclk high");
   property p_strobe_pulse;
      $rose(strobe) && strobe_oe && !cs_n && !sclk && rst_n && power_down_n
         |-> strobe [*8] ##1 strobe [*8] ##1 !strobe;
   endproperty
   a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe pulse width");
   property p_strobe_low;
      $fell(strobe) && strobe_oe && rst_n |-> (!strobe) [*8];
   endproperty
   a_strobe_low: assert property (p_strobe_low) else $error("strobe low too short");
   property p_reset_clear;
      (!rst_n) [*5] |-> !user_out_zero && !user_out_one && !user_out_two && strobe;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("hard reset not applied");
   property p_user_keep;
      (rst_n && !power_down_n) [*5] |-> $stable({user_out_two, user_out_one, user_out_zero});
   endproperty
   a_user_keep: assert property (p_user_keep) else $error("user outs moved in shutdown");
endmodule

// ### sim/adc_serial_host_port_tb.sv
`timescale 1ns/1ps
module adc_serial_host_port_tb import ashp_pkg::*;;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic pready, pslverr, irq, shutdown, dbusy, rerr, sclk_q, strb_q;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rdat;
   logic [15:0] code = 16'h0;
   int n_mismatch = 0, checks = 0, falls = 0, strb_at = -1;
   ashp_if bus();
   wire [2:0] uo = {bus.user_out_two, bus.user_out_one, bus.user_out_zero};

   ashp_host #(.SCLK_HALF(8)) ashp_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .link(bus.host));
   ashp_device #(.CONV_CYC(64)) ashp_device_i (.pclk(pclk), .presetn(presetn),
      .link(bus.dev), .analog_code(code), .shutdown(shutdown), .busy(dbusy));
   ashp_properties ashp_properties_i (.pclk(pclk), .presetn(presetn), .cs_n(bus.cs_n),
      .sclk(bus.sclk), .din(bus.din), .dout(bus.dout), .dout_oe(bus.dout_oe),
      .strobe(bus.strobe), .strobe_oe(bus.strobe_oe), .power_down_n(bus.power_down_n),
      .rst_n(bus.rst_n), .user_out_zero(bus.user_out_zero), .user_out_one(bus.user_out_one),
      .user_out_two(bus.user_out_two));

   always #2 pclk = ~pclk;

   // Counts sclk falls in a frame and notes the count at the strobe rise
   always @(posedge pclk) begin
      sclk_q <= bus.sclk;
      strb_q <= bus.strobe_w;
      if (bus.cs_n) falls <= 0;
      else if (sclk_q && !bus.sclk) falls <= falls + 1;
      if (!bus.cs_n && strb_q === 1'b0 && bus.strobe_w === 1'b1) strb_at <= falls;
   end

   // ----------------------------------------------------------------
   // Bus tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic xfer(input logic [7:0] cb, input logic [5:0] len);
      strb_at = -1;
      apb(1'b1, ASHP_OFF_CTRL, {18'h0, len, cb});
      do apb(1'b0, ASHP_OFF_STAT, 32'h0); while (rdat[0] !== 1'b0);
      apb(1'b0, ASHP_OFF_RX, 32'h0);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_idle();
      apb(1'b0, ASHP_OFF_PIN, 32'h0);
      chk("pin_rst", {30'h0, ASHP_PIN_RST_VAL}, rdat);
      apb(1'b0, ASHP_OFF_MASK, 32'h0);
      chk("mask_rst", 32'h0, rdat);
      apb(1'b1, 8'h18, 32'hffffffff);
      chk("unmapped_err", 32'h1, {31'h0, rerr});
      apb(1'b0, 8'h18, 32'h0);
      chk("unmapped_rd", 32'h0, rdat);
      chk("dout_z", 32'h0, {31'h0, bus.dout_oe});
      chk("user_rst", 32'h0, {29'h0, uo});
   endtask

   task automatic t_ext();
      logic [7:0] cbs [4] = '{8'h85, 8'hc2, 8'h93, 8'hd4};
      logic [15:0] cvs [4] = '{16'h1234, 16'h0001, 16'hfffe, 16'h8000};
      logic [15:0] ex;
      xfer(8'h80, 6'h18);
      for (int i = 0; i < 4; i++) begin
         code <= cvs[i];
         xfer(cbs[i], cbs[i][ASHP_CB_LONG] ? 6'h20 : 6'h18);
         ex = cvs[i] ^ (cbs[i][ASHP_CB_BIP] ? ASHP_BIP_FLIP : 16'h0);
         chk("result", {16'h0, ex}, {16'h0, rdat[15:0]});
         chk("strobe_at", cbs[i][ASHP_CB_LONG] ? 32'hf : 32'h7, strb_at);
         chk("user_outs", {29'h0, cbs[i][2:0]}, {29'h0, uo});
      end
      xfer(8'h88, 6'h18);
      chk("cal_strobe", 32'hffffffff, strb_at);
      chk("cal_outs", 32'h0, {29'h0, uo});
      chk("dout_off", 32'h0, {31'h0, bus.dout_oe});
      chk("strobe_off", 32'h0, {31'h0, bus.strobe_oe});
   endtask

   task automatic t_int();
      int n = 0;
      code <= 16'h5a5a;
      apb(1'b1, ASHP_OFF_IRQ, 32'h3);
      xfer(8'ha0, 6'h08);
      chk("strobe_conv", 32'h0, {31'h0, bus.strobe_w});
      while (bus.strobe_w !== 1'b1 && n < 200) begin
         @(posedge pclk);
         n++;
      end
      chk("strobe_done", 32'h1, {31'h0, bus.strobe_w});
      repeat (4) @(posedge pclk);
      apb(1'b0, ASHP_OFF_IRQ, 32'h0);
      chk("irq_stat", 32'h3, rdat);
      chk("irq_masked", 32'h0, {31'h0, irq});
      apb(1'b1, ASHP_OFF_MASK, 32'h2);
      @(posedge pclk);
      chk("irq_on", 32'h1, {31'h0, irq});
      apb(1'b1, ASHP_OFF_IRQ, 32'h3);
      @(posedge pclk);
      chk("irq_off", 32'h0, {31'h0, irq});
      xfer(8'h00, 6'h10);
      chk("int_result", 32'h5a5a, {16'h0, rdat[15:0]});
   endtask

   task automatic t_abort();
      code <= 16'h0f0f;
      xfer(8'h80, 6'h0c);
      chk("stalled", 32'h1, {31'h0, dbusy});
      code <= 16'h3c3c;
      xfer(8'h01, 6'h1f);
      chk("restart", 32'h3c3c, {16'h0, rdat[15:0]});
      chk("strobe_lead0", 32'he, strb_at);
   endtask

   task automatic t_pins();
      code <= 16'h7e81;
      xfer(8'h87, 6'h18);
      apb(1'b1, ASHP_OFF_PIN, 32'h2);
      repeat (4) @(posedge pclk);
      apb(1'b0, ASHP_OFF_STAT, 32'h0);
      chk("stat_pd", 32'h1, {31'h0, rdat[2]});
      chk("shutdown", 32'h1, {31'h0, shutdown});
      chk("user_keep", 32'h7, {29'h0, uo});
      apb(1'b1, ASHP_OFF_PIN, 32'h3);
      xfer(8'h87, 6'h04);
      apb(1'b1, ASHP_OFF_PIN, 32'h1);
      repeat (8) @(posedge pclk);
      chk("user_clr", 32'h0, {29'h0, uo});
      chk("strobe_clr", 32'h1, {31'h0, bus.strobe_w});
      apb(1'b1, ASHP_OFF_PIN, 32'h3);
      code <= 16'h0100;
      xfer(8'hc6, 6'h18);
      chk("after_rst", 32'h8100, {16'h0, rdat[15:0]});
      chk("user_new", 32'h6, {29'h0, uo});
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   task automatic print_verdict();
      if (n_mismatch == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_idle();
      t_ext();
      t_int();
      t_abort();
      t_pins();
      print_verdict();
   end

   initial begin
      repeat (30000) @(posedge pclk);
      n_mismatch++;
      print_verdict();
   end
endmodule
